// [hdl/gen_pkg.sv]
// constants, state codes, register map and pattern helpers shared by the
// pattern generator and its debug controller; both ends share clk/reset_n.
//
// Operation
// - idle until calibration done, then traffic
// - read data mismatch raises compare error
// - go input lets start advance to load
// - controller holds go low through reset if programming
// - without programming, go stays high (here go only resets high; a CTRL write can still clear it)
// - generator reset input is synchronous, level
// - reset or rerun held until traffic drains
// - rerun level restarts after done, pause, error
// - hold input suspends issuing traffic
// - stop-on-error halts at first error, else continue
// - after error stop, retest classifies read/write
// - clear-nonsticky edge clears all but sticky
// - clear-everything edge clears all incl. sticky
// - clears take effect two cycles after edge
// - controller pulses clears only in errdone/paused
// - resume edge in errdone restarts traffic
// - drive memory only through user command port
`default_nettype none
package gen_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] NUM_WORDS = 5'h10;
  localparam int ADDR_LSB = 3; // one burst of eight columns per word
  localparam logic [DATA_W-1:0] DATA_SEED = 32'h5A5AA5A5;
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;

  typedef enum logic [2:0] {
    state_start = 3'b000,
    state_load = 3'b001,
    state_write = 3'b010,
    state_read = 3'b011,
    state_paused = 3'b100,
    state_done = 3'b101,
    state_error_test = 3'b110,
    state_error_done = 3'b111
  } gen_state_e;

  // controller register map (byte offsets) and fields
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_CMD = 8'h04;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [REG_AW-1:0] OFS_HOLD_CYC = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_STOP_ERR = 2;
  localparam int CMD_RESET = 0;
  localparam int CMD_RERUN = 1;
  localparam int CMD_CLR_NS = 2;
  localparam int CMD_CLR_ALL = 3;
  localparam int CMD_RESUME = 4;
  localparam int IRQ_CMP_ERR = 0;
  localparam int IRQ_ERR_DONE = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_W = 3;
  localparam int HOLD_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_CYC_RESET = 16'h0010;

  function automatic logic [ADDR_W-1:0] addr_of(logic [IDX_W-1:0] idx);
    return ADDR_W'({idx, {ADDR_LSB{1'b0}}});
  endfunction

  function automatic logic [DATA_W-1:0] pattern_of(logic [IDX_W-1:0] idx);
    return DATA_SEED ^ DATA_W'(addr_of(idx));
  endfunction
endpackage
`default_nettype wire

// [hdl/gen_ctrl_if.sv]
// control and status link between the debug controller and the pattern
// generator; both ends run on the same clock, no synchroniser needed.
`default_nettype none
interface gen_ctrl_if;
  import gen_pkg::*;
  logic gen_go_in;
  logic gen_sync_reset_in;
  logic gen_rerun_in;
  logic gen_hold_in;
  logic stop_on_error_enable;
  logic error_clear_nonsticky;
  logic error_clear_everything;
  logic error_resume_in;
  gen_state_e gen_state_out;
  logic compare_error;
  logic sticky_error;
  logic read_error;
  logic write_error;

  modport gen (
    input gen_go_in, gen_sync_reset_in, gen_rerun_in, gen_hold_in,
    input stop_on_error_enable, error_clear_nonsticky,
    input error_clear_everything, error_resume_in,
    output gen_state_out, compare_error, sticky_error, read_error,
    output write_error
  );
  modport ctrl (
    output gen_go_in, gen_sync_reset_in, gen_rerun_in, gen_hold_in,
    output stop_on_error_enable, error_clear_nonsticky,
    output error_clear_everything, error_resume_in,
    input gen_state_out, compare_error, sticky_error, read_error,
    input write_error
  );
endinterface
`default_nettype wire

// [hdl/advanced_pattern_generator.sv]
// pattern generator: writes NUM_WORDS words, reads them back and compares,
// under level and edge controls from the debug link.
// assumes the memory user command port and the link share clk/reset_n.
//
// Implementation choices: the strobed register port and the register addresses.
`default_nettype none
module advanced_pattern_generator (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic init_calib_complete,
  gen_ctrl_if.gen link,
  output logic app_en,
  output logic [2:0] app_cmd,
  output logic [gen_pkg::ADDR_W-1:0] app_addr,
  output logic [gen_pkg::DATA_W-1:0] app_wdf_data,
  output logic app_wdf_wren,
  output logic app_wdf_end,
  input wire logic app_rdy,
  input wire logic app_wdf_rdy,
  input wire logic app_rd_data_valid,
  input wire logic [gen_pkg::DATA_W-1:0] app_rd_data
);
  import gen_pkg::*;

  gen_state_e state_reg;
  gen_state_e paused_from_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [IDX_W-1:0] rd_cmd_idx_reg;
  logic [IDX_W-1:0] rd_ret_idx_reg;
  logic [IDX_W-1:0] fail_idx_reg;
  logic retest_sent_reg;
  logic app_en_reg;
  logic [2:0] app_cmd_reg;
  logic [ADDR_W-1:0] app_addr_reg;
  logic [DATA_W-1:0] app_wdf_data_reg;
  logic app_wdf_wren_reg;
  logic cmp_err_reg;
  logic sticky_reg;
  logic rd_err_reg;
  logic wr_err_reg;
  logic clr_ns_prev_reg;
  logic clr_all_prev_reg;
  logic resume_prev_reg;
  logic [1:0] clr_ns_pipe_reg;
  logic [1:0] clr_all_pipe_reg;
  logic mismatch;
  logic checking;
  logic retest_back;
  logic stop_now;
  logic clear_ok;
  logic resume_edge;
  logic drained;

  // compare against the pattern of the next expected return
  assign mismatch = app_rd_data_valid &&
                    (app_rd_data != pattern_of(rd_ret_idx_reg));
  assign checking = (state_reg == state_read) ||
                    (state_reg == state_paused);
  assign retest_back = (state_reg == state_error_test) && retest_sent_reg &&
                       app_rd_data_valid;
  assign stop_now = link.stop_on_error_enable && mismatch &&
                    (state_reg == state_read);
  assign clear_ok = (state_reg == state_error_done) ||
                    (state_reg == state_paused);
  assign resume_edge = link.error_resume_in && !resume_prev_reg;
  assign drained = (rd_ret_idx_reg == rd_cmd_idx_reg) && !app_rd_data_valid;

  // sequencer: command issue, counters and state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= state_start;
      paused_from_reg <= state_write;
      wr_idx_reg <= '0;
      rd_cmd_idx_reg <= '0;
      rd_ret_idx_reg <= '0;
      fail_idx_reg <= '0;
      retest_sent_reg <= 1'b0;
      app_en_reg <= 1'b0;
      app_cmd_reg <= CMD_WRITE;
      app_addr_reg <= '0;
      app_wdf_data_reg <= '0;
      app_wdf_wren_reg <= 1'b0;
    end else if (link.gen_sync_reset_in) begin
      // level reset: stays here as long as the input is high
      state_reg <= state_start;
      wr_idx_reg <= '0;
      rd_cmd_idx_reg <= '0;
      rd_ret_idx_reg <= '0;
      retest_sent_reg <= 1'b0;
      app_en_reg <= 1'b0;
      app_wdf_wren_reg <= 1'b0;
    end else begin
      // returns are counted except the single retest word
      if (app_rd_data_valid &&
          !(state_reg == state_error_test && retest_sent_reg)) begin
        rd_ret_idx_reg <= rd_ret_idx_reg + 1'b1;
      end
      if (state_reg == state_read && app_en_reg && app_rdy) begin
        rd_cmd_idx_reg <= rd_cmd_idx_reg + 1'b1;
      end
      unique case (state_reg)
        state_start: begin
          if (link.gen_go_in && init_calib_complete) begin
            state_reg <= state_load;
          end
        end
        state_load: begin
          wr_idx_reg <= '0;
          rd_cmd_idx_reg <= '0;
          rd_ret_idx_reg <= '0;
          retest_sent_reg <= 1'b0;
          if (!link.gen_rerun_in) begin
            state_reg <= state_write;
          end
        end
        state_write: begin
          if (link.gen_hold_in) begin
            // an unaccepted command is withdrawn while held
            state_reg <= state_paused;
            paused_from_reg <= state_write;
            app_en_reg <= 1'b0;
            app_wdf_wren_reg <= 1'b0;
          end else if (app_en_reg && app_rdy && app_wdf_rdy) begin
            app_en_reg <= 1'b0;
            app_wdf_wren_reg <= 1'b0;
            wr_idx_reg <= wr_idx_reg + 1'b1;
            if (wr_idx_reg == NUM_WORDS - 1'b1) begin
              state_reg <= state_read;
            end
          end else if (!app_en_reg) begin
            app_en_reg <= 1'b1;
            app_cmd_reg <= CMD_WRITE;
            app_addr_reg <= addr_of(wr_idx_reg);
            app_wdf_data_reg <= pattern_of(wr_idx_reg);
            app_wdf_wren_reg <= 1'b1;
          end
        end
        state_read: begin
          if (stop_now) begin
            state_reg <= state_error_test;
            fail_idx_reg <= rd_ret_idx_reg;
            retest_sent_reg <= 1'b0;
            app_en_reg <= 1'b0;
          end else if (link.gen_hold_in) begin
            state_reg <= state_paused;
            paused_from_reg <= state_read;
            app_en_reg <= 1'b0;
          end else if (rd_cmd_idx_reg == NUM_WORDS &&
                       rd_ret_idx_reg == NUM_WORDS) begin
            state_reg <= state_done;
          end else if (app_en_reg && app_rdy) begin
            app_en_reg <= 1'b0;
          end else if (!app_en_reg && rd_cmd_idx_reg != NUM_WORDS) begin
            app_en_reg <= 1'b1;
            app_cmd_reg <= CMD_READ;
            app_addr_reg <= addr_of(rd_cmd_idx_reg);
          end
        end
        state_paused: begin
          if (link.gen_rerun_in) begin
            state_reg <= state_load;
          end else if (!link.gen_hold_in) begin
            state_reg <= paused_from_reg;
          end
        end
        state_done: begin
          if (link.gen_rerun_in) begin
            state_reg <= state_load;
          end
        end
        state_error_test: begin
          // drain reads in flight, then re-read the failing word once
          if (app_en_reg) begin
            if (app_rdy) begin
              app_en_reg <= 1'b0;
              retest_sent_reg <= 1'b1;
            end
          end else if (!retest_sent_reg && drained) begin
            app_en_reg <= 1'b1;
            app_cmd_reg <= CMD_READ;
            app_addr_reg <= addr_of(fail_idx_reg);
          end else if (retest_back) begin
            state_reg <= state_error_done;
          end
        end
        state_error_done: begin
          if (link.gen_rerun_in) begin
            state_reg <= state_load;
          end else if (resume_edge) begin
            state_reg <= state_read;
            retest_sent_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // edge detection and the two-stage clear delay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_ns_prev_reg <= 1'b0;
      clr_all_prev_reg <= 1'b0;
      resume_prev_reg <= 1'b0;
      clr_ns_pipe_reg <= '0;
      clr_all_pipe_reg <= '0;
    end else begin
      clr_ns_prev_reg <= link.error_clear_nonsticky;
      clr_all_prev_reg <= link.error_clear_everything;
      resume_prev_reg <= link.error_resume_in;
      clr_ns_pipe_reg <= {clr_ns_pipe_reg[0], link.error_clear_nonsticky &&
                          !clr_ns_prev_reg && clear_ok};
      clr_all_pipe_reg <= {clr_all_pipe_reg[0], link.error_clear_everything &&
                           !clr_all_prev_reg && clear_ok};
    end
  end

  // error flags: a new error in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_err_reg <= 1'b0;
      sticky_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      wr_err_reg <= 1'b0;
    end else if (link.gen_sync_reset_in) begin
      cmp_err_reg <= 1'b0;
      sticky_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      wr_err_reg <= 1'b0;
    end else begin
      if (clr_ns_pipe_reg[1] || clr_all_pipe_reg[1]) begin
        cmp_err_reg <= 1'b0;
        rd_err_reg <= 1'b0;
        wr_err_reg <= 1'b0;
      end
      if (clr_all_pipe_reg[1]) begin
        sticky_reg <= 1'b0;
      end
      if (checking && mismatch) begin
        cmp_err_reg <= 1'b1;
        sticky_reg <= 1'b1;
      end
      // retest data good means the array holds the right word
      if (retest_back) begin
        if (app_rd_data == pattern_of(fail_idx_reg)) begin
          rd_err_reg <= 1'b1;
        end else begin
          wr_err_reg <= 1'b1;
        end
      end
    end
  end

  assign app_en = app_en_reg;
  assign app_cmd = app_cmd_reg;
  assign app_addr = app_addr_reg;
  assign app_wdf_data = app_wdf_data_reg;
  assign app_wdf_wren = app_wdf_wren_reg;
  assign app_wdf_end = app_wdf_wren_reg; // single-beat bursts
  assign link.gen_state_out = state_reg;
  assign link.compare_error = cmp_err_reg;
  assign link.sticky_error = sticky_reg;
  assign link.read_error = rd_err_reg;
  assign link.write_error = wr_err_reg;
endmodule // advanced_pattern_generator
`default_nettype wire

// [hdl/gen_debug_controller.sv]
// debug controller: software registers in, generator control levels and
// edges out, status and one interrupt back. assumes the same clk/reset_n.
`default_nettype none
module gen_debug_controller #(
  parameter bit PLAN_PROGRAMMING = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [gen_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  gen_ctrl_if.ctrl link
);
  import gen_pkg::*;

  logic go_reg;
  logic hold_reg;
  logic stop_err_reg;
  logic [HOLD_W-1:0] hold_cyc_reg;
  logic [HOLD_W-1:0] rst_cnt_reg;
  logic [HOLD_W-1:0] rerun_cnt_reg;
  logic rst_out_reg;
  logic rerun_out_reg;
  logic clr_ns_reg;
  logic clr_all_reg;
  logic resume_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic cmp_prev_reg;
  gen_state_e state_prev_reg;
  logic [31:0] rdata_reg;
  logic cmd_wr;
  logic clear_window;
  logic [IRQ_W-1:0] events;
  logic [31:0] read_mux;

  assign cmd_wr = reg_wr && (reg_addr == OFS_CMD);
  assign clear_window = (link.gen_state_out == state_error_done) ||
                        (link.gen_state_out == state_paused);

  // a hold length of zero still gives one cycle
  function automatic logic [HOLD_W-1:0] hold_len(logic [HOLD_W-1:0] n);
    return (n == '0) ? HOLD_W'(1) : n;
  endfunction

  // control levels; go starts low only if programming is planned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      go_reg <= !PLAN_PROGRAMMING;
      hold_reg <= 1'b0;
      stop_err_reg <= 1'b0;
      hold_cyc_reg <= HOLD_CYC_RESET;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      go_reg <= reg_wdata[CTRL_GO];
      hold_reg <= reg_wdata[CTRL_HOLD];
      stop_err_reg <= reg_wdata[CTRL_STOP_ERR];
    end else if (reg_wr && reg_addr == OFS_HOLD_CYC) begin
      hold_cyc_reg <= reg_wdata[HOLD_W-1:0];
    end
  end

  // reset and rerun are held for a programmed number of cycles so that
  // reads still in the memory pipeline can return first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
      rerun_cnt_reg <= '0;
      rst_out_reg <= 1'b0;
      rerun_out_reg <= 1'b0;
    end else begin
      if (cmd_wr && reg_wdata[CMD_RESET]) begin
        rst_cnt_reg <= hold_len(hold_cyc_reg) - 1'b1;
        rst_out_reg <= 1'b1;
      end else if (rst_cnt_reg != '0) begin
        rst_cnt_reg <= rst_cnt_reg - 1'b1;
      end else begin
        rst_out_reg <= 1'b0;
      end
      if (cmd_wr && reg_wdata[CMD_RERUN]) begin
        rerun_cnt_reg <= hold_len(hold_cyc_reg) - 1'b1;
        rerun_out_reg <= 1'b1;
      end else if (rerun_cnt_reg != '0) begin
        rerun_cnt_reg <= rerun_cnt_reg - 1'b1;
      end else begin
        rerun_out_reg <= 1'b0;
      end
    end
  end

  // one-cycle edges, refused outside the states that allow them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_ns_reg <= 1'b0;
      clr_all_reg <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      clr_ns_reg <= cmd_wr && reg_wdata[CMD_CLR_NS] && clear_window;
      clr_all_reg <= cmd_wr && reg_wdata[CMD_CLR_ALL] && clear_window;
      resume_reg <= cmd_wr && reg_wdata[CMD_RESUME] &&
                    (link.gen_state_out == state_error_done);
    end
  end

  // interrupt sources: new compare error, error-done and done entry
  assign events[IRQ_CMP_ERR] = link.compare_error && !cmp_prev_reg;
  assign events[IRQ_ERR_DONE] = (link.gen_state_out == state_error_done) &&
                                (state_prev_reg != state_error_done);
  assign events[IRQ_DONE] = (link.gen_state_out == state_done) &&
                            (state_prev_reg != state_done);

  // write-one-to-clear, an event in the same cycle wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | events;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
      cmp_prev_reg <= 1'b0;
      state_prev_reg <= state_start;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        irq_reg <= |(irq_stat_next & reg_wdata[IRQ_W-1:0]);
      end else begin
        irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
      cmp_prev_reg <= link.compare_error;
      state_prev_reg <= link.gen_state_out;
    end
  end

  // read mux; unmapped offsets and the command register read zero
  always_comb begin
    read_mux = '0;
    unique case (reg_addr)
      OFS_CTRL: read_mux = 32'({stop_err_reg, hold_reg, go_reg});
      OFS_STATUS: read_mux = 32'({link.sticky_error, link.write_error,
                                  link.read_error, link.compare_error,
                                  link.gen_state_out});
      OFS_IRQ_STAT: read_mux = 32'(irq_stat_reg);
      OFS_IRQ_MASK: read_mux = 32'(irq_mask_reg);
      OFS_HOLD_CYC: read_mux = 32'(hold_cyc_reg);
      default: read_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? read_mux : '0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign link.gen_go_in = go_reg;
  assign link.gen_hold_in = hold_reg;
  assign link.stop_on_error_enable = stop_err_reg;
  assign link.gen_sync_reset_in = rst_out_reg;
  assign link.gen_rerun_in = rerun_out_reg;
  assign link.error_clear_nonsticky = clr_ns_reg;
  assign link.error_clear_everything = clr_all_reg;
  assign link.error_resume_in = resume_reg;
endmodule // gen_debug_controller
`default_nettype wire

// [dv/gen_link_props.sv]
// checker on the control link between debug controller and generator
// assumes one clock domain shared by both ends, reset_n active low
`default_nettype none
module gen_link_props
  import gen_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic gen_sync_reset_in,
  input wire logic gen_rerun_in,
  input wire logic gen_hold_in,
  input wire logic stop_on_error_enable,
  input wire logic error_clear_nonsticky,
  input wire logic error_clear_everything,
  input wire logic error_resume_in,
  input wire gen_state_e gen_state_out,
  input wire logic compare_error,
  input wire logic sticky_error,
  input wire logic read_error,
  input wire logic write_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // nonsticky clears keep the sticky bit; three edges cover the two-cycle pipe
  clear_keeps_sticky_a: assert property (
    $rose(error_clear_nonsticky) && gen_state_out == state_error_done
    |-> ##3 !compare_error && !read_error && !write_error
    && sticky_error == $past(sticky_error, 3))
    else $error("nonsticky clear left flags or lost sticky");
  clear_all_timed_a: assert property (
    $rose(error_clear_everything) && gen_state_out == state_error_done
    |-> ##2 sticky_error ##1 (!sticky_error && !compare_error
    && !read_error && !write_error))
    else $error("clear all not taken exactly two cycles later");
  clear_gate_a: assert property (
    error_clear_nonsticky || error_clear_everything
    |-> $past(gen_state_out) inside {state_paused, state_error_done})
    else $error("clear pulse sent in wrong state");
  resume_gate_a: assert property (
    error_resume_in |-> $past(gen_state_out) == state_error_done)
    else $error("resume pulse sent outside error done");
  resume_run_a: assert property (
    $rose(error_resume_in) && gen_state_out == state_error_done
    |-> ##[1:4] gen_state_out == state_read)
    else $error("resume did not restart reads");
  sync_reset_a: assert property (
    gen_sync_reset_in |=> gen_state_out == state_start
    && !sticky_error && !compare_error)
    else $error("sync reset not applied");
  hold_pause_a: assert property (
    $rose(gen_hold_in) && !gen_rerun_in && !gen_sync_reset_in
    && gen_state_out inside {state_write, state_read}
    |-> ##[1:3] gen_state_out == state_paused)
    else $error("hold did not pause traffic");
  rerun_load_a: assert property (
    gen_rerun_in && !gen_sync_reset_in
    && gen_state_out inside {state_paused, state_done, state_error_done}
    |=> gen_state_out == state_load)
    else $error("rerun did not restart");
  stop_error_a: assert property (
    $rose(compare_error) && stop_on_error_enable
    |-> ##[0:2] gen_state_out == state_error_test)
    else $error("no stop on first error");
  retest_class_a: assert property (
    gen_state_out == state_error_done
    && $past(gen_state_out) == state_error_test
    |-> read_error != write_error)
    else $error("failure not classified");
endmodule // gen_link_props
`default_nettype wire

// [dv/test_memory_traffic_generator_control.sv]
// bench: controller and generator joined by the link, a small memory
// answering the command port; software reaches only the register port
`default_nettype none
module test_memory_traffic_generator_control;
  timeunit 1ns;
  timeprecision 1ps;
  import gen_pkg::*;
  logic clk = 0, reset_n = 0, calib = 0, rdy = 1, slow = 0;
  logic rflip = 0, wflip = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, mem [0:31];
  logic reg_wr = 0, reg_rd = 0, irq, app_en, app_wdf_wren, app_wdf_end;
  logic [2:0] app_cmd;
  logic [27:0] app_addr;
  logic [31:0] app_wdf_data, app_rd_data = 32'h0;
  logic app_rd_data_valid = 0;
  int bad_count = 0, n_compared = 0;

  gen_ctrl_if gen_ctrl_if_inst ();
  gen_debug_controller gen_debug_controller_inst (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .link(gen_ctrl_if_inst));
  advanced_pattern_generator advanced_pattern_generator_inst (.clk(clk),
    .reset_n(reset_n), .init_calib_complete(calib), .link(gen_ctrl_if_inst),
    .app_en(app_en), .app_cmd(app_cmd), .app_addr(app_addr),
    .app_wdf_data(app_wdf_data), .app_wdf_wren(app_wdf_wren),
    .app_wdf_end(app_wdf_end), .app_rdy(rdy), .app_wdf_rdy(rdy),
    .app_rd_data_valid(app_rd_data_valid), .app_rd_data(app_rd_data));
  gen_link_props gen_link_props_inst (.clk(clk), .reset_n(reset_n),
    .gen_sync_reset_in(gen_ctrl_if_inst.gen_sync_reset_in),
    .gen_rerun_in(gen_ctrl_if_inst.gen_rerun_in),
    .gen_hold_in(gen_ctrl_if_inst.gen_hold_in),
    .stop_on_error_enable(gen_ctrl_if_inst.stop_on_error_enable),
    .error_clear_nonsticky(gen_ctrl_if_inst.error_clear_nonsticky),
    .error_clear_everything(gen_ctrl_if_inst.error_clear_everything),
    .error_resume_in(gen_ctrl_if_inst.error_resume_in),
    .gen_state_out(gen_ctrl_if_inst.gen_state_out),
    .compare_error(gen_ctrl_if_inst.compare_error),
    .sticky_error(gen_ctrl_if_inst.sticky_error),
    .read_error(gen_ctrl_if_inst.read_error),
    .write_error(gen_ctrl_if_inst.write_error));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // memory side: slow mode stalls every other cycle; flips inject faults
  always @(posedge clk) begin
    rdy <= slow ? ~rdy : 1'b1;
    app_rd_data_valid <= 1'b0;
    if (app_en && rdy) begin
      if (app_cmd === CMD_WRITE) begin
        chk("wdata", app_wdf_data, DATA_SEED ^ 32'(app_addr));
        chk("wdf_end", 32'(app_wdf_end), 32'(app_wdf_wren));
        mem[app_addr[7:3]] <= app_wdf_data
          ^ 32'(wflip && app_addr[7:3] == 5'h05);
      end else begin
        app_rd_data_valid <= 1'b1;
        app_rd_data <= mem[app_addr[7:3]] ^ 32'(rflip);
        rflip <= 1'b0;
      end
    end
  end

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_st(gen_state_e s);
    int n;
    n = 0;
    while (gen_ctrl_if_inst.gen_state_out !== s && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("state", 32'(gen_ctrl_if_inst.gen_state_out), 32'(s));
  endtask

  task automatic status_is(logic [31:0] e);
    rd(OFS_STATUS, d);
    chk("status", d & 32'h0000007F, e);
  endtask

  task automatic t_calib_irq();
    repeat (20) @(posedge clk);
    chk("idle_state", 32'(gen_ctrl_if_inst.gen_state_out), 32'h0);
    chk("idle_en", 32'(app_en), 32'h0);
    calib <= 1'b1;
    wait_st(state_done);
    status_is(32'h00000005);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h00000004);
    rd(OFS_IRQ_STAT, d);
    chk("irq_stat", d, 32'h00000004);
    chk("irq_on", 32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h00000004);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    chk("irq_off", 32'(irq), 32'h0);
  endtask

  task automatic t_hold();
    slow <= 1'b1;
    wr(OFS_CMD, 32'h00000002);
    wait_st(state_write);
    wr(OFS_CTRL, 32'h00000003);
    wait_st(state_paused);
    repeat (6) @(posedge clk);
    chk("paused_en", 32'(app_en), 32'h0);
    wr(OFS_CTRL, 32'h00000001);
    wait_st(state_done);
    slow <= 1'b0;
  endtask

  task automatic t_read_err();
    wr(OFS_CTRL, 32'h00000005);
    rflip <= 1'b1;
    wr(OFS_CMD, 32'h00000002);
    wait_st(state_error_done);
    status_is(32'h0000005F);
    wr(OFS_CMD, 32'h00000004);
    repeat (4) @(posedge clk);
    status_is(32'h00000047);
    wr(OFS_CMD, 32'h00000010);
    wait_st(state_done);
    wr(OFS_CMD, 32'h00000008);
    repeat (4) @(posedge clk);
    status_is(32'h00000045);
  endtask

  task automatic t_write_err();
    wflip <= 1'b1;
    wr(OFS_CMD, 32'h00000002);
    wait_st(state_error_done);
    status_is(32'h0000006F);
    wr(OFS_CMD, 32'h00000008);
    repeat (4) @(posedge clk);
    status_is(32'h00000007);
    wr(OFS_CTRL, 32'h00000001);
    wr(OFS_CMD, 32'h00000002);
    wait_st(state_done);
    status_is(32'h0000004D);
    wflip <= 1'b0;
  endtask

  task automatic t_sync_reset();
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_CMD, 32'h00000001);
    repeat (3) @(posedge clk);
    status_is(32'h00000000);
    repeat (20) @(posedge clk);
    status_is(32'h00000000);
    wr(OFS_CTRL, 32'h00000001);
    wait_st(state_done);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs several hundred cycles
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_calib_irq();
    t_hold();
    t_read_err();
    t_write_err();
    t_sync_reset();
    finish_test();
  end
endmodule // test_memory_traffic_generator_control
`default_nettype wire
